// ===== rtl/pdc_divider_config.sv
// APB register file and clock dividers for the multiplier's reference, feedback and output paths
//
// Operation
// R1: Reference clock divided before phase detector
// R2: Reference divisor ten bits, split over two
// R3: Codes 3 to 1023 divide by code
// R4: Codes zero and one pass undivided
// R5: Software never writes divisor two
// R6: Software sets enable for divisor effect
// R7: Enable clear bypasses reference divider
// R8: Oscillator divided by prescale in feedback
// R9: Prescale twelve bits, split over two
// R10: Prescale zero undivided, else divide by code
// R11: Prescale resets to 120
// R12: Output divider code zero undivided, else code
// R13: Software keeps reserved bits at reset values
// R14: Split divisors commit after both halves written
`timescale 1ns/1ns
module pdc_divider_config (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Undivided clocks from pins
  input  wire logic        ref_clk_in,
  input  wire logic        osc_clk_in,
  input  wire logic        mult_clk_in,
  // Divided clocks
  output logic             ref_div_clk,
  output logic             fb_div_clk,
  output logic             out_div_clk
);

  // Selector decode shared by read and write paths
  function automatic pdc_pkg::pdc_sel_t sel_of(input logic [11:0] a);
    if (a == pdc_pkg::ADDR_REF_LOW) begin
      sel_of = pdc_pkg::PDC_SEL_REFL;
    end else if (a == pdc_pkg::ADDR_OUT_REFH) begin
      sel_of = pdc_pkg::PDC_SEL_OREF;
    end else if (a == pdc_pkg::ADDR_FB_LOW) begin
      sel_of = pdc_pkg::PDC_SEL_FBL;
    end else if (a == pdc_pkg::ADDR_FB_HIGH) begin
      sel_of = pdc_pkg::PDC_SEL_FBH;
    end else if (a == pdc_pkg::ADDR_ENABLE) begin
      sel_of = pdc_pkg::PDC_SEL_EN;
    end else begin
      sel_of = pdc_pkg::PDC_SEL_NONE;
    end
  endfunction

  // Code to ratio: zero means undivided, anything else divides by itself
  function automatic logic [11:0] ratio_of(input logic [11:0] code);
    ratio_of = (code == 12'h0000) ? pdc_pkg::RATIO_ONE : code;
  endfunction

  pdc_pkg::pdc_sel_t   sel;
  logic                setup;
  logic                wr_go;
  logic [7:0]          ref_low_q;
  logic [7:0]          out_refh_q;
  logic [7:0]          fb_low_q;
  logic [7:0]          fb_high_q;
  logic [7:0]          enable_q;
  logic [1:0]          ref_half_q;
  logic [1:0]          fb_half_q;
  logic [1:0]          ref_half_d;
  logic [1:0]          fb_half_d;
  logic [9:0]          ref_code_q;
  logic [11:0]         fb_code_q;
  logic [9:0]          ref_new;
  logic [11:0]         fb_new;
  logic                ref_commit;
  logic                fb_commit;
  logic                pready_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic [7:0]          rd_byte;
  pdc_pkg::pdc_ratio_t ratio;
  logic [11:0]         ratio_arr [3];
  logic [2:0]          clk_in;
  logic [2:0]          div_q;

  localparam logic [11:0] RATIO_ONE_L = pdc_pkg::RATIO_ONE;

  assign sel   = sel_of(paddr);
  assign setup = psel && penable && !pready_q;
  // A write lands only on the edge where pready is sampled high
  assign wr_go = psel && penable && pready_q && pwrite;

  // One wait state per transfer; read data captured with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && (sel == pdc_pkg::PDC_SEL_NONE);
      if (setup) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Read mux; unmapped and unimplemented bits read zero
  always_comb begin
    if (sel == pdc_pkg::PDC_SEL_REFL) begin
      rd_byte = ref_low_q;
    end else if (sel == pdc_pkg::PDC_SEL_OREF) begin
      rd_byte = out_refh_q;
    end else if (sel == pdc_pkg::PDC_SEL_FBL) begin
      rd_byte = fb_low_q;
    end else if (sel == pdc_pkg::PDC_SEL_FBH) begin
      rd_byte = fb_high_q;
    end else if (sel == pdc_pkg::PDC_SEL_EN) begin
      rd_byte = enable_q & pdc_pkg::ENABLE_RD_MASK;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Byte registers; reserved bits stored as written, software keeps them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_low_q  <= pdc_pkg::RST_REF_LOW;
      out_refh_q <= pdc_pkg::RST_OUT_REFH;
      fb_low_q   <= pdc_pkg::RST_FB_LOW;
      fb_high_q  <= pdc_pkg::RST_FB_HIGH; // [R11]
      enable_q   <= pdc_pkg::RST_ENABLE;
    end else if (wr_go) begin
      if (sel == pdc_pkg::PDC_SEL_REFL) begin
        ref_low_q <= pwdata[7:0];
      end else if (sel == pdc_pkg::PDC_SEL_OREF) begin
        out_refh_q <= pwdata[7:0];
      end else if (sel == pdc_pkg::PDC_SEL_FBL) begin
        fb_low_q <= pwdata[7:0];
      end else if (sel == pdc_pkg::PDC_SEL_FBH) begin
        fb_high_q <= pwdata[7:0];
      end else if (sel == pdc_pkg::PDC_SEL_EN) begin
        enable_q <= pwdata[7:0];
      end
    end
  end

  // Half-written tracking: a pair commits once both bytes have landed
  always_comb begin
    ref_half_d = ref_half_q;
    fb_half_d  = fb_half_q;
    if (wr_go && sel == pdc_pkg::PDC_SEL_REFL) begin
      ref_half_d[0] = 1'b1;
    end
    if (wr_go && sel == pdc_pkg::PDC_SEL_OREF) begin
      ref_half_d[1] = 1'b1;
    end
    if (wr_go && sel == pdc_pkg::PDC_SEL_FBL) begin
      fb_half_d[0] = 1'b1;
    end
    if (wr_go && sel == pdc_pkg::PDC_SEL_FBH) begin
      fb_half_d[1] = 1'b1;
    end
  end

  assign ref_commit = &ref_half_d; // [R14]
  assign fb_commit  = &fb_half_d;  // [R14]
  // New pair values, taking the byte being written this cycle
  assign ref_new = {(wr_go && sel == pdc_pkg::PDC_SEL_OREF) ? pwdata[pdc_pkg::REFH_MSB:0]
                                                          : out_refh_q[pdc_pkg::REFH_MSB:0],
                    (wr_go && sel == pdc_pkg::PDC_SEL_REFL) ? pwdata[7:0] : ref_low_q}; // [R2]
  assign fb_new  = {(wr_go && sel == pdc_pkg::PDC_SEL_FBH) ? pwdata[pdc_pkg::FBH_MSB:0]
                                                         : fb_high_q[pdc_pkg::FBH_MSB:0],
                    (wr_go && sel == pdc_pkg::PDC_SEL_FBL) ? pwdata[7:0] : fb_low_q}; // [R9]

  // Applied divisor codes; reference code two is ignored so the old ratio stays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_half_q <= 2'b00;
      fb_half_q  <= 2'b00;
      ref_code_q <= {pdc_pkg::RST_OUT_REFH[1:0], pdc_pkg::RST_REF_LOW};
      fb_code_q  <= pdc_pkg::RST_FB_CODE; // [R11]
    end else begin
      ref_half_q <= ref_commit ? 2'b00 : ref_half_d;
      fb_half_q  <= fb_commit ? 2'b00 : fb_half_d;
      if (ref_commit && ref_new != pdc_pkg::REF_CODE_UNSUPPORTED) begin // [R5]
        ref_code_q <= ref_new;
      end
      if (fb_commit) begin
        fb_code_q <= fb_new;
      end
    end
  end

  // Ratio selection; enable clear bypasses the reference divider
  assign ratio.ref_ratio = enable_q[pdc_pkg::REF_EN_BIT] ? ratio_of({2'b00, ref_code_q})
                                                         : pdc_pkg::RATIO_ONE; // [R3] [R4] [R7]
  assign ratio.fb_ratio  = ratio_of(fb_code_q); // [R10]
  assign ratio.out_ratio = ratio_of({8'h00, out_refh_q[7:pdc_pkg::OUTDIV_LSB]}); // [R12]
  assign ratio_arr[0] = ratio.ref_ratio;
  assign ratio_arr[1] = ratio.fb_ratio;
  assign ratio_arr[2] = ratio.out_ratio;
  assign clk_in = {mult_clk_in, osc_clk_in, ref_clk_in};

  // Dividers: pins sampled at pclk, so inputs must stay below half its rate.
  // Output is high for the input's high phase once every ratio rising edges.
  for (genvar i = 0; i < 3; i++) begin : g_div
    logic [2:0]  sync_q;
    logic [11:0] cnt_q;
    logic        out_q;
    logic        rise;

    assign rise     = sync_q[1] && !sync_q[2];
    assign div_q[i] = out_q;

    // Two-flop synchroniser, third flop for edge detect
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync_q <= 3'b000;
      end else begin
        sync_q <= {sync_q[1:0], clk_in[i]};
      end
    end

    // Edge counter wraps at ratio; a count at or above a lowered ratio wraps at the next edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= 12'h000;
        out_q <= 1'b0;
      end else begin
        if (rise) begin
          cnt_q <= (cnt_q >= ratio_arr[i] - RATIO_ONE_L) ? 12'h000 : cnt_q + RATIO_ONE_L;
        end
        // Only the zero count opens a pulse, so one pulse per ratio edges
        out_q <= sync_q[1] && (rise ? (cnt_q == 12'h000) : out_q); // [R1] [R8]
      end
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign ref_div_clk = div_q[0];
  assign fb_div_clk  = div_q[1];
  assign out_div_clk = div_q[2];

  // Checks
  property p_ready_one;
    @(posedge pclk) disable iff (!presetn) setup |=> pready_q ##1 !pready_q;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready not a single cycle after setup");

  property p_bypass;
    @(posedge pclk) disable iff (!presetn) !enable_q[pdc_pkg::REF_EN_BIT] |-> ratio.ref_ratio == 12'h001;
  endproperty
  a_bypass: assert property (p_bypass) else $error("reference divider not bypassed"); // [R7]

  property p_ref_low;
    @(posedge pclk) disable iff (!presetn) ref_code_q <= 10'h001 |-> ratio.ref_ratio == 12'h001;
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("codes zero and one must pass through"); // [R4]

  property p_ref_code;
    @(posedge pclk) disable iff (!presetn)
      enable_q[pdc_pkg::REF_EN_BIT] && ref_code_q >= 10'h003 |-> ratio.ref_ratio == {2'b00, ref_code_q};
  endproperty
  a_ref_code: assert property (p_ref_code) else $error("reference ratio differs from code"); // [R3]

  property p_ref_two;
    @(posedge pclk) disable iff (!presetn) ref_commit && ref_new == 10'h002 |=> $stable(ref_code_q);
  endproperty
  a_ref_two: assert property (p_ref_two) else $error("divisor two changed the division"); // [R5]

  property p_fb_ratio;
    @(posedge pclk) disable iff (!presetn)
      ratio.fb_ratio == ((fb_code_q == 12'h000) ? 12'h001 : fb_code_q);
  endproperty
  a_fb_ratio: assert property (p_fb_ratio) else $error("prescale ratio wrong"); // [R10]

  property p_half;
    @(posedge pclk) disable iff (!presetn)
      wr_go && sel == pdc_pkg::PDC_SEL_FBL && !fb_half_q[1] |=> $stable(fb_code_q) && fb_half_q == 2'b01;
  endproperty
  a_half: assert property (p_half) else $error("prescale applied after one half"); // [R14]

  property p_fb_reset;
    @(posedge pclk) $rose(presetn) |-> fb_code_q == 12'h078;
  endproperty
  a_fb_reset: assert property (p_fb_reset) else $error("prescale reset value not 120"); // [R11]

  property p_out_ratio;
    @(posedge pclk) disable iff (!presetn)
      out_refh_q[7:4] == 4'h0 |-> ratio.out_ratio == 12'h001;
  endproperty
  a_out_ratio: assert property (p_out_ratio) else $error("output code zero not undivided"); // [R12]

  property p_div_gap;
    @(posedge pclk) disable iff (!presetn) div_q[1] |-> $past(g_div[1].sync_q[1]);
  endproperty
  a_div_gap: assert property (p_div_gap) else $error("feedback divider high while input low"); // [R8]

endmodule

// ===== rtl/pdc_pkg.sv
// Constants and types for the clock-multiplier divider configuration block
package pdc_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_REF_LOW  = 8'h54;
  localparam logic [7:0]  IDX_OUT_REFH = 8'h55;
  localparam logic [7:0]  IDX_FB_LOW   = 8'h56;
  localparam logic [7:0]  IDX_FB_HIGH  = 8'h57;
  localparam logic [7:0]  IDX_ENABLE   = 8'h59;
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ADDR_REF_LOW  = {2'b00, IDX_REF_LOW, 2'b00};
  localparam logic [11:0] ADDR_OUT_REFH = {2'b00, IDX_OUT_REFH, 2'b00};
  localparam logic [11:0] ADDR_FB_LOW   = {2'b00, IDX_FB_LOW, 2'b00};
  localparam logic [11:0] ADDR_FB_HIGH  = {2'b00, IDX_FB_HIGH, 2'b00};
  localparam logic [11:0] ADDR_ENABLE   = {2'b00, IDX_ENABLE, 2'b00};

  // Values after power-on reset
  localparam logic [7:0] RST_REF_LOW  = 8'h00;
  localparam logic [7:0] RST_OUT_REFH = 8'h48;
  localparam logic [7:0] RST_FB_LOW   = 8'h78;
  localparam logic [7:0] RST_FB_HIGH  = 8'h40;
  localparam logic [7:0] RST_ENABLE   = 8'h41;

  // Field positions
  localparam int OUTDIV_LSB   = 4;
  localparam int REFH_MSB     = 1;
  localparam int FBH_MSB      = 3;
  localparam int REF_EN_BIT   = 4;
  localparam logic [7:0] ENABLE_RD_MASK = 8'h7F;

  // Divider widths and special codes
  localparam int RATIO_W = 12;
  localparam logic [9:0]  REF_CODE_UNSUPPORTED = 10'h002;
  localparam logic [11:0] RATIO_ONE            = 12'h0001;
  localparam logic [11:0] RST_FB_CODE          = {RST_FB_HIGH[3:0], RST_FB_LOW};

  // One-hot register selector
  typedef enum logic [5:0] {
    PDC_SEL_NONE = 6'b00_0001,
    PDC_SEL_REFL = 6'b00_0010,
    PDC_SEL_OREF = 6'b00_0100,
    PDC_SEL_FBL  = 6'b00_1000,
    PDC_SEL_FBH  = 6'b01_0000,
    PDC_SEL_EN   = 6'b10_0000
  } pdc_sel_t;

  // Applied division ratios of the three dividers
  typedef struct packed {
    logic [RATIO_W-1:0] out_ratio;
    logic [RATIO_W-1:0] fb_ratio;
    logic [RATIO_W-1:0] ref_ratio;
  } pdc_ratio_t;

endpackage

// ===== dv/pdc_divider_config_test.sv
// Self-checking bench for the divider configuration block
`timescale 1ns/1ns
module pdc_divider_config_test;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        src_clk;
  logic        ref_div_clk;
  logic        fb_div_clk;
  logic        out_div_clk;
  logic [1:0]  ph;
  int          n_mismatch;
  int          compares;
  int          cyc;

  pdc_divider_config pdc_divider_config_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clk_in(src_clk), .osc_clk_in(src_clk), .mult_clk_in(src_clk),
    .ref_div_clk(ref_div_clk), .fb_div_clk(fb_div_clk), .out_div_clk(out_div_clk)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Source clocks at 16 ns, derived from pclk so edges never race the sampler
  always @(posedge pclk) begin
    ph <= ph + 2'd1;
    if (ph[0]) src_clk <= ~src_clk;
  end

  // Hang guard: longest ratio takes about 50k cycles on its own
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0000_0000, e}, 32'h0000_0000);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h00_0000, x});
    chk({31'h0000_0000, e}, 32'h0000_0000);
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? ref_div_clk : (w == 1) ? fb_div_clk : out_div_clk;
  endfunction

  // Period between the second and third rise, so stale pipeline pulses drop out
  task automatic meas(input int w, input int ratio);
    int  n;
    int  r;
    int  a;
    logic p;
    n = 0;
    r = 0;
    a = 0;
    p = pick(w);
    while (r < 3 && n < 70000) begin
      @(posedge pclk);
      n++;
      if (pick(w) === 1'b1 && p !== 1'b1) begin
        r++;
        if (r == 2) a = n;
      end
      p = pick(w);
    end
    chk(n - a, 4 * ratio);
  endtask

  task automatic t_reset();
    rd(pdc_pkg::ADDR_REF_LOW, 8'h00);
    rd(pdc_pkg::ADDR_OUT_REFH, 8'h48);
    rd(pdc_pkg::ADDR_FB_LOW, 8'h78);
    rd(pdc_pkg::ADDR_FB_HIGH, 8'h40);
    rd(pdc_pkg::ADDR_ENABLE, 8'h41);
    meas(0, 1);
    meas(1, 120);
    meas(2, 4);
  endtask

  task automatic t_ref();
    int codes[5] = '{3, 5, 0, 3, 1};
    int ratio[5] = '{3, 5, 1, 3, 1};
    wr(pdc_pkg::ADDR_REF_LOW, 8'hFF);
    wr(pdc_pkg::ADDR_OUT_REFH, 8'h4B);
    rd(pdc_pkg::ADDR_OUT_REFH, 8'h4B);
    meas(0, 1);
    wr(pdc_pkg::ADDR_ENABLE, 8'hD1);
    rd(pdc_pkg::ADDR_ENABLE, 8'h51);
    meas(0, 1023);
    wr(pdc_pkg::ADDR_REF_LOW, 8'h02);
    wr(pdc_pkg::ADDR_OUT_REFH, 8'h48);
    meas(0, 1023);
    for (int i = 0; i < 5; i++) begin
      wr(pdc_pkg::ADDR_REF_LOW, 8'(codes[i]));
      if (i == 1) meas(0, 3);
      wr(pdc_pkg::ADDR_OUT_REFH, 8'h48);
      meas(0, ratio[i]);
    end
    wr(pdc_pkg::ADDR_REF_LOW, 8'h05);
    wr(pdc_pkg::ADDR_OUT_REFH, 8'h48);
    wr(pdc_pkg::ADDR_ENABLE, 8'h41);
    meas(0, 1);
  endtask

  task automatic t_fb();
    wr(pdc_pkg::ADDR_FB_HIGH, 8'h4F);
    meas(1, 120);
    wr(pdc_pkg::ADDR_FB_LOW, 8'hFF);
    meas(1, 4095);
    wr(pdc_pkg::ADDR_FB_LOW, 8'h00);
    wr(pdc_pkg::ADDR_FB_HIGH, 8'h40);
    meas(1, 1);
    wr(pdc_pkg::ADDR_FB_HIGH, 8'h41);
    wr(pdc_pkg::ADDR_FB_LOW, 8'h07);
    meas(1, 263);
  endtask

  task automatic t_out();
    int ratio[5] = '{1, 1, 2, 3, 4};
    for (int i = 0; i < 5; i++) begin
      wr(pdc_pkg::ADDR_OUT_REFH, {4'(i), 4'h8});
      meas(2, ratio[i]);
    end
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h160, 8'hA5, r, e);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    apb(1'b0, 12'h160, 8'h00, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
  endtask

  initial begin
    presetn    = 1'b0;
    paddr      = 12'h000;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    pwdata     = 32'h0000_0000;
    src_clk    = 1'b0;
    ph         = 2'd0;
    n_mismatch = 0;
    compares   = 0;
    cyc        = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ref();
    t_fb();
    t_out();
    t_unmapped();
    tally_and_finish();
  end
endmodule
